// ==== bt_handshake_control_flags_test.sv ====
`timescale 1ns/100ps
module bt_handshake_control_flags_test;
  import bthsc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, host_wr_in, host_rd_in, host_irq_out, irq_out;
  logic [7:0] host_wdata_in, host_rdata_out;
  logic hr_q = 1'b0;
  logic [32:0] exp_q[$];
  logic [15:0] rnd = 16'h3374;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  bthsc_control bthsc_control_i (.sys_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .host_wr_in, .host_rd_in,
    .host_wdata_in, .host_rdata_out, .host_irq_out, .irq_out);
  bthsc_host_model bthsc_host_model_i (.sys_clk_in, .host_wr_out(host_wr_in),
    .host_rd_out(host_rd_in), .host_wdata_out(host_wdata_in));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The top 16 bits of write data are random noise that the register must ignore
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    rnd = lfsr(rnd);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {rnd, 8'h00, d};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task hx(input logic w, input logic [7:0] d, input logic [7:0] e);
    exp_q.push_back({25'h0, e});
    bthsc_host_model_i.xfer(w, d);
  endtask
  task lvl(input logic h, input logic s);
    repeat (2) @(posedge sys_clk_in);
    chk({31'h0, host_irq_out, irq_out}, {31'h0, h, s});
  endtask
  always @(posedge sys_clk_in) begin
    hr_q <= host_rd_in;
    cycles++;
    if (pready_out === 1'b1 && pwrite_in === 1'b0)
      chk({pslverr_out, prdata_out}, exp_q.pop_front());
    if (hr_q === 1'b1)
      chk({25'h0, host_rdata_out}, exp_q.pop_front());
    if (cycles > 3000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rd(BTHSC_ADDR_CONTROL, 33'h80);
    hx(1'b0, 8'h00, 8'h80);
    hx(1'b1, 8'h20, 8'h80);
    apb(1'b1, BTHSC_ADDR_CONTROL, 8'h78);
    rd(BTHSC_ADDR_CONTROL, 33'h38);
    lvl(1'b0, 1'b0);
    apb(1'b1, BTHSC_ADDR_HOST_MASK, 8'h01);
    lvl(1'b1, 1'b0);
    hx(1'b1, 8'h10, 8'h28);
    lvl(1'b1, 1'b0);
    hx(1'b1, 8'h08, 8'h20);
    lvl(1'b0, 1'b0);
    hx(1'b1, 8'h40, 8'h60);
    hx(1'b1, 8'h40, 8'h20);
    apb(1'b1, BTHSC_ADDR_CONTROL, 8'h00);
    rd(BTHSC_ADDR_CONTROL, 33'h00);
    hx(1'b1, 8'h00, 8'h20);
    rd(BTHSC_ADDR_IRQ_STATUS, 33'h0f);
    lvl(1'b0, 1'b0);
    apb(1'b1, BTHSC_ADDR_IRQ_MASK, 8'h0f);
    lvl(1'b0, 1'b1);
    apb(1'b1, BTHSC_ADDR_IRQ_STATUS, 8'h0f);
    lvl(1'b0, 1'b0);
    rd(BTHSC_ADDR_IRQ_STATUS, 33'h00);
    for (int i = 0; i < 4; i++) begin
      rd(8'h10 | (rnd[7:0] & 8'hf0), 33'h1_0000_0000);
      apb(1'b1, 8'h10 | (rnd[7:0] & 8'hf0), 8'hff);
    end
    rd(BTHSC_ADDR_CONTROL, 33'h20);
    // Reset in mid-run must bring back the reset image after flags have moved
    rst_b_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rd(BTHSC_ADDR_CONTROL, 33'h80);
    rd(BTHSC_ADDR_HOST_MASK, 33'h00);
    hx(1'b0, 8'h00, 8'h80);
    test_done();
  end
endmodule

// ==== bthsc_control.sv ====
`timescale 1ns/100ps

// How it works
// (R1) Bit 7 write-busy flag resets to 1; slave reads and writes, host reads.
// (R2) Bit 6 read-busy flag resets to 0; slave may only read it.
// (R3) Host writing 1 to bit 6 inverts the read-busy flag.
// (R4) Bit 5 user flag: slave sets after reading 0, clears after reading 1.
// (R5) Host writing 0 to bit 5 sets the user flag; host never clears it.
// (R6) Bit 4 event attention: slave sets by writing 1 after reading 0.
// (R7) Host writing 1 to bit 4 clears the event attention flag.
// (R8) Event attention requests a host interrupt while host enable is 1.
// (R9) Bit 3 write-done attention resets to 0, marks slave finished filling buffer.
// (R10) Write-done attention requests a host interrupt while host enable is 1.
// (R11) Write-done set by slave 1 after reading 0; cleared by host writing 1.
// (R12) Host interrupt is a level: enable and either attention flag high.
module bthsc_control #(
  parameter int HOST_DATA_W = bthsc_pkg::BTHSC_REG_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // APB slave, used by the embedded processor
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [bthsc_pkg::BTHSC_APB_ADDR_W-1:0] paddr_in,
  input wire logic [bthsc_pkg::BTHSC_APB_DATA_W-1:0] pwdata_in,
  output logic [bthsc_pkg::BTHSC_APB_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Host access to the handshake control register
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [HOST_DATA_W-1:0] host_wdata_in,
  output logic [HOST_DATA_W-1:0] host_rdata_out,
  output logic host_irq_out,
  // Slave-side interrupt
  output logic irq_out
);
  import bthsc_pkg::*;

  // The register image is zero-extended into the APB word by fixed-width padding in the
  // functions below, so any other width is refused when the block is built.
  if (HOST_DATA_W != BTHSC_REG_W) begin : g_host_width_check
    $error("HOST_DATA_W must equal the control register width");
  end
  if (BTHSC_REG_W + 24 != BTHSC_APB_DATA_W) begin : g_reg_pad_check
    $error("The control register must pad to exactly one APB word");
  end
  if (BTHSC_IRQ_W + 28 != BTHSC_APB_DATA_W) begin : g_irq_pad_check
    $error("The interrupt fields must pad to exactly one APB word");
  end

  function automatic logic addr_is(input logic [BTHSC_APB_ADDR_W-1:0] a,
                                   input logic [BTHSC_APB_ADDR_W-1:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  function automatic logic [BTHSC_APB_DATA_W-1:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction

  function automatic logic [BTHSC_APB_DATA_W-1:0] zext_irq(input logic [BTHSC_IRQ_W-1:0] v);
    zext_irq = {28'h0000000, v};
  endfunction

  // APB handshake: one wait state, so pready and read data both come from flops
  // The extra cycle costs bus bandwidth but keeps the bus inputs off every output path
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [BTHSC_APB_DATA_W-1:0] prdata_q;
  logic [BTHSC_APB_DATA_W-1:0] prdata_d;

  // Decode compares the whole byte address, so aliases of a register are refused
  wire access_w = psel_in & penable_in;
  wire hit_control = addr_is(paddr_in, BTHSC_ADDR_CONTROL);
  wire hit_host_mask = addr_is(paddr_in, BTHSC_ADDR_HOST_MASK);
  wire hit_irq_status = addr_is(paddr_in, BTHSC_ADDR_IRQ_STATUS);
  wire hit_irq_mask = addr_is(paddr_in, BTHSC_ADDR_IRQ_MASK);
  wire hit_any = hit_control | hit_host_mask | hit_irq_status | hit_irq_mask;

  // Writes and reads commit on the completing edge only
  // pready_q marks the access cycle in which the answer stands
  wire done_w = access_w & pready_q;
  wire wr_commit = done_w & pwrite_in & hit_any;
  wire rd_commit = done_w & ~pwrite_in & hit_control;
  wire wr_control = wr_commit & hit_control;
  wire wr_host_mask = wr_commit & hit_host_mask;
  wire wr_irq_status = wr_commit & hit_irq_status;
  wire wr_irq_mask = wr_commit & hit_irq_mask;
  // Only the low byte of a slave write matters; upper write data is ignored
  wire [7:0] slave_wdata = pwdata_in[7:0];

  // Flag state
  logic write_busy_q;
  logic write_busy_d;
  logic read_busy;
  logic user_flag;
  logic event_attention;
  logic slave_write_done_attention;
  logic host_interrupt_enable_q;
  logic host_interrupt_enable_d;

  // Value of the control register as the slave last read it. It resets to all zero,
  // so before its first read the slave can set bits 5..3 by writing 1 but cannot
  // clear the user flag by writing 0; drivers should read before they write.
  logic [7:0] slave_seen_q;
  logic [7:0] slave_seen_d;

  // Bits 2..0 belong to functions outside this block and always read as zero
  wire [7:0] bt_handshake_control = {
    write_busy_q,
    read_busy,
    user_flag,
    event_attention,
    slave_write_done_attention,
    3'b000
  } & BTHSC_CONTROL_IMPL_MASK;

  // Slave-side set and clear qualifiers, gated by what the slave saw last
  wire seen_user = slave_seen_q[BTHSC_BIT_USER_FLAG];
  wire seen_event = slave_seen_q[BTHSC_BIT_EVENT_ATTN];
  wire seen_done = slave_seen_q[BTHSC_BIT_DONE_ATTN];
  wire slave_user_set = wr_control & slave_wdata[BTHSC_BIT_USER_FLAG] & ~seen_user; // R4
  wire slave_user_clr = wr_control & ~slave_wdata[BTHSC_BIT_USER_FLAG] & seen_user; // R4
  wire slave_event_set = wr_control & slave_wdata[BTHSC_BIT_EVENT_ATTN] & ~seen_event; // R6
  wire slave_done_set = wr_control & slave_wdata[BTHSC_BIT_DONE_ATTN] & ~seen_done; // R11

  // Host-side effects of a write. Bits that carry no meaning for a flag in the
  // written direction are ignored; the host gets no error for them.
  wire host_read_busy_tgl = host_wr_in & host_wdata_in[BTHSC_BIT_READ_BUSY]; // R3
  wire host_user_set = host_wr_in & ~host_wdata_in[BTHSC_BIT_USER_FLAG]; // R5
  wire host_event_clr = host_wr_in & host_wdata_in[BTHSC_BIT_EVENT_ATTN]; // R7
  wire host_done_clr = host_wr_in & host_wdata_in[BTHSC_BIT_DONE_ATTN]; // R11

  // Bit 7 belongs to the slave alone
  // It follows every slave write of the control word, whatever the slave last read
  always_comb begin
    write_busy_d = write_busy_q;
    if (wr_control) begin
      write_busy_d = slave_wdata[BTHSC_BIT_WRITE_BUSY]; // R1
    end
  end

  // Only the host moves bit 6; slave writes to it are dropped
  // A host write of 1 flips it, so a host that loses track must read before it writes
  bthsc_flag #(
    .RESET_VAL(BTHSC_RST_READ_BUSY)
  ) u_read_busy (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .set_in(1'b0),
    .clr_in(1'b0),
    .toggle_in(host_read_busy_tgl),
    .flag_out(read_busy)
  ); // R2

  // A host set and a slave clear in the same cycle leave the flag set
  bthsc_flag #(
    .RESET_VAL(BTHSC_RST_USER_FLAG)
  ) u_user_flag (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .set_in(slave_user_set | host_user_set),
    .clr_in(slave_user_clr),
    .toggle_in(1'b0),
    .flag_out(user_flag)
  ); // R4 R5

  // A slave raising an event as the host acknowledges keeps the new event
  bthsc_flag #(
    .RESET_VAL(BTHSC_RST_EVENT_ATTN)
  ) u_event_attention (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .set_in(slave_event_set),
    .clr_in(host_event_clr),
    .toggle_in(1'b0),
    .flag_out(event_attention)
  ); // R6 R7

  // Same priority: a fresh write-done from the slave survives a host acknowledge
  bthsc_flag #(
    .RESET_VAL(BTHSC_RST_DONE_ATTN)
  ) u_done_attention (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .set_in(slave_done_set),
    .clr_in(host_done_clr),
    .toggle_in(1'b0),
    .flag_out(slave_write_done_attention)
  ); // R9 R11

  // Snapshot on each slave read of the control register. It takes the word the slave
  // really received, latched one edge earlier, so a host write landing in the wait
  // state cannot make a later slave write act on a value the slave never saw.
  wire [7:0] slave_read_image = prdata_q[7:0];

  always_comb begin
    slave_seen_d = slave_seen_q;
    if (rd_commit) begin
      slave_seen_d = slave_read_image;
    end
  end

  // Only bit 0 of the host mask word is kept
  always_comb begin
    host_interrupt_enable_d = host_interrupt_enable_q;
    if (wr_host_mask) begin
      host_interrupt_enable_d = pwdata_in[BTHSC_BIT_HOST_IRQ_EN];
    end
  end

  // Host interrupt level, registered so the pin is glitch free
  // It trails the flags by one cycle, so it can still be seen just after an acknowledge
  wire host_irq_d = host_interrupt_enable_q
                    & (event_attention | slave_write_done_attention); // R8 R10 R12

  // Host read data, one cycle after the read strobe
  // A read and a write on the same edge return the value from before the write
  logic [HOST_DATA_W-1:0] host_rdata_q;
  logic [HOST_DATA_W-1:0] host_rdata_d;

  always_comb begin
    host_rdata_d = host_rdata_q;
    if (host_rd_in) begin
      host_rdata_d = bt_handshake_control;
    end
  end

  // Slave-side interrupt: host activity sets sticky bits, writing 1 clears
  // Each status bit records a host action, so the slave need not poll the control word;
  // an acknowledge only counts when the flag it is aimed at was set
  logic [BTHSC_IRQ_W-1:0] irq_status_q;
  logic [BTHSC_IRQ_W-1:0] irq_status_d;
  logic [BTHSC_IRQ_W-1:0] irq_mask_q;
  logic [BTHSC_IRQ_W-1:0] irq_mask_d;
  logic irq_q;

  wire [BTHSC_IRQ_W-1:0] irq_events = {
    host_done_clr & slave_write_done_attention,
    host_event_clr & event_attention,
    host_user_set & ~user_flag,
    host_read_busy_tgl
  };
  // Write-one-to-clear: only the bits written as 1 are cleared
  wire [BTHSC_IRQ_W-1:0] irq_clear = wr_irq_status ? pwdata_in[BTHSC_IRQ_W-1:0]
                                                   : {BTHSC_IRQ_W{1'b0}};

  // Set wins over a write-one-to-clear landing in the same cycle
  always_comb begin
    irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
  end

  always_comb begin
    irq_mask_d = irq_mask_q;
    if (wr_irq_mask) begin
      irq_mask_d = pwdata_in[BTHSC_IRQ_W-1:0];
    end
  end

  // Built from next status and mask, so irq_out moves on the same edge as the status
  wire irq_d = |(irq_status_d & irq_mask_d);

  // APB answer path
  // Unmapped offsets answer with an error and zero data; writes to them do nothing
  always_comb begin
    pready_d = access_w & ~pready_q;
    pslverr_d = access_w & ~pready_q & ~hit_any;
    prdata_d = '0;
    if (access_w & ~pready_q & ~pwrite_in) begin
      if (hit_control) begin
        prdata_d = zext8(bt_handshake_control);
      end else if (hit_host_mask) begin
        prdata_d = zext8({7'h00, host_interrupt_enable_q});
      end else if (hit_irq_status) begin
        prdata_d = zext_irq(irq_status_q);
      end else if (hit_irq_mask) begin
        prdata_d = zext_irq(irq_mask_q);
      end else begin
        prdata_d = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      write_busy_q <= BTHSC_RST_WRITE_BUSY; // R1
      host_interrupt_enable_q <= BTHSC_RST_HOST_IRQ_EN;
      slave_seen_q <= '0;
    end else begin
      write_busy_q <= write_busy_d;
      host_interrupt_enable_q <= host_interrupt_enable_d;
      slave_seen_q <= slave_seen_d;
    end
  end

  logic host_irq_q;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      host_irq_q <= 1'b0;
      host_rdata_q <= '0;
    end else begin
      host_irq_q <= host_irq_d; // R12
      host_rdata_q <= host_rdata_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      irq_status_q <= BTHSC_RST_IRQ_STATUS;
      irq_mask_q <= BTHSC_RST_IRQ_MASK;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign prdata_out = prdata_q;
  assign host_rdata_out = host_rdata_q;
  assign host_irq_out = host_irq_q;
  assign irq_out = irq_q;

endmodule

// ==== bthsc_control_asserts.sv ====
`timescale 1ns/100ps
module bthsc_control_asserts #(
  parameter int HOST_DATA_W = bthsc_pkg::BTHSC_REG_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [bthsc_pkg::BTHSC_APB_ADDR_W-1:0] paddr_in,
  input wire logic [bthsc_pkg::BTHSC_APB_DATA_W-1:0] pwdata_in,
  input wire logic [bthsc_pkg::BTHSC_APB_DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [HOST_DATA_W-1:0] host_wdata_in,
  input wire logic [HOST_DATA_W-1:0] host_rdata_out,
  input wire logic host_irq_out,
  input wire logic irq_out
);
  import bthsc_pkg::*;
  logic en_q;
  logic en_d;
  wire commit = psel_in && penable_in && pready_out;
  wire en_wr = commit && pwrite_in && paddr_in == BTHSC_ADDR_HOST_MASK;
  // Shadow of the host enable, so the interrupt is judged from the ports alone
  assign en_d = en_wr ? pwdata_in[BTHSC_BIT_HOST_IRQ_EN] : en_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in)
      en_q <= 1'b0;
    else
      en_q <= en_d;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_ready_wait;
    psel_in && penable_in && !pready_out |=> pready_out;
  endproperty
  property p_ready_pulse;
    pready_out |-> psel_in && penable_in ##1 !pready_out;
  endproperty
  property p_unmapped;
    commit && paddr_in[7:4] != 4'h0 |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  property p_low_zero;
    host_rd_in |=> host_rdata_out[2:0] == 3'h0;
  endproperty
  property p_rdbusy_toggle;
    host_rd_in && !host_wr_in ##1 !host_wr_in ##1 host_wr_in && host_wdata_in[6] ##1 host_rd_in
      |=> host_rdata_out[6] != $past(host_rdata_out[6], 3);
  endproperty
  property p_user_set;
    host_wr_in && !host_wdata_in[5] && !psel_in ##1 host_rd_in && !psel_in
      |=> host_rdata_out[5];
  endproperty
  property p_attn_clear;
    host_wr_in && !psel_in ##1 host_rd_in && !psel_in
      |=> (host_rdata_out[4:3] & $past(host_wdata_in[4:3], 2)) == 2'h0;
  endproperty
  property p_host_irq_off;
    !en_q && !$past(en_q) |-> !host_irq_out;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready missing");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready stray");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_low_zero: assert property (p_low_zero) else $error("low bits not zero");
  a_rdbusy_toggle: assert property (p_rdbusy_toggle) else $error("no toggle");
  a_user_set: assert property (p_user_set) else $error("user flag not set");
  a_attn_clear: assert property (p_attn_clear) else $error("attn kept");
  a_host_irq_off: assert property (p_host_irq_off) else $error("irq unmasked");
  c_slverr: cover property (commit && pslverr_out);
  c_host_irq: cover property (host_irq_out);
  c_irq: cover property (irq_out);
endmodule

bind bthsc_control bthsc_control_asserts #(.HOST_DATA_W(HOST_DATA_W)) bthsc_control_asserts_i (
  .sys_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .host_wr_in, .host_rd_in, .host_wdata_in,
  .host_rdata_out, .host_irq_out, .irq_out);

// ==== bthsc_flag.sv ====
`timescale 1ns/100ps

// One handshake flag; a set request wins over a clear in the same cycle
module bthsc_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic set_in,
  input wire logic clr_in,
  input wire logic toggle_in,
  output logic flag_out
);

  logic flag_d;

  always_comb begin
    if (set_in) begin
      flag_d = 1'b1;
    end else if (clr_in) begin
      flag_d = 1'b0;
    end else if (toggle_in) begin
      flag_d = ~flag_out;
    end else begin
      flag_d = flag_out;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      flag_out <= RESET_VAL;
    end else begin
      flag_out <= flag_d;
    end
  end

endmodule

// ==== bthsc_host_model.sv ====
`timescale 1ns/100ps
module bthsc_host_model (
  input wire logic sys_clk_in,
  output logic host_wr_out,
  output logic host_rd_out,
  output logic [7:0] host_wdata_out
);
  initial begin
    host_wr_out = 1'b0;
    host_rd_out = 1'b0;
    host_wdata_out = 8'h00;
  end
  // Optional write, then a read taken on the very next edge
  task xfer(input logic w, input logic [7:0] d);
    @(posedge sys_clk_in);
    if (w) begin
      host_wr_out <= 1'b1;
      host_wdata_out <= d;
      @(posedge sys_clk_in);
      host_wdata_out <= ~d;
    end
    host_wr_out <= 1'b0;
    host_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    host_rd_out <= 1'b0;
  endtask
endmodule

// ==== bthsc_pkg.sv ====
package bthsc_pkg;

  // APB byte addresses of the slave-side register map
  localparam logic [7:0] BTHSC_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] BTHSC_ADDR_HOST_MASK = 8'h04;
  localparam logic [7:0] BTHSC_ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] BTHSC_ADDR_IRQ_MASK = 8'h0c;

  // Handshake control register bit positions
  localparam int BTHSC_BIT_WRITE_BUSY = 7;
  localparam int BTHSC_BIT_READ_BUSY = 6;
  localparam int BTHSC_BIT_USER_FLAG = 5;
  localparam int BTHSC_BIT_EVENT_ATTN = 4;
  localparam int BTHSC_BIT_DONE_ATTN = 3;

  // Handshake control register reset values
  localparam logic BTHSC_RST_WRITE_BUSY = 1'b1;
  localparam logic BTHSC_RST_READ_BUSY = 1'b0;
  localparam logic BTHSC_RST_USER_FLAG = 1'b0;
  localparam logic BTHSC_RST_EVENT_ATTN = 1'b0;
  localparam logic BTHSC_RST_DONE_ATTN = 1'b0;

  // Bits 2..0 are not implemented here and read as zero
  localparam logic [7:0] BTHSC_CONTROL_IMPL_MASK = 8'hf8;

  // Host interrupt mask register: enable bit position and reset
  localparam int BTHSC_BIT_HOST_IRQ_EN = 0;
  localparam logic BTHSC_RST_HOST_IRQ_EN = 1'b0;

  // Slave-side interrupt status bits, set by host activity
  localparam int BTHSC_IRQ_READ_BUSY_TOGGLED = 0;
  localparam int BTHSC_IRQ_USER_FLAG_SET = 1;
  localparam int BTHSC_IRQ_EVENT_ACKED = 2;
  localparam int BTHSC_IRQ_DONE_ACKED = 3;
  localparam int BTHSC_IRQ_W = 4;
  localparam logic [BTHSC_IRQ_W-1:0] BTHSC_RST_IRQ_STATUS = 4'h0;
  localparam logic [BTHSC_IRQ_W-1:0] BTHSC_RST_IRQ_MASK = 4'h0;

  localparam int BTHSC_APB_DATA_W = 32;
  localparam int BTHSC_APB_ADDR_W = 8;
  localparam int BTHSC_REG_W = 8;

endpackage
